/* File: rtl/sfp_pkg.sv */
// sfp_pkg: shared constants and types for the serial flash front end
package sfp_pkg;

  // ----------------------------------------------------------------
  // operation codes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OP_WRITE_BYTES  = 8'h02;
  localparam logic [7:0] OP_READ_BYTES   = 8'h03;
  localparam logic [7:0] OP_WRITE_OFF    = 8'h04;
  localparam logic [7:0] OP_READ_STATUS  = 8'h05;
  localparam logic [7:0] OP_WRITE_ON     = 8'h06;
  localparam logic [7:0] OP_ERASE_BULK   = 8'hC7;
  localparam logic [7:0] OP_ERASE_DIE    = 8'hC4;
  localparam logic [7:0] OP_ERASE_SECTOR = 8'hD8;

  // ----------------------------------------------------------------
  // status register layout and reset value
  // ----------------------------------------------------------------
  localparam int         ST_BUSY_POS   = 0;
  localparam int         ST_PERMIT_POS = 1;
  localparam int         ST_LEVEL_LSB  = 2;
  localparam int         ST_ORIGIN_POS = 5;
  localparam int         ST_RSVD_LSB   = 6;
  localparam logic [7:0] ST_RESET      = 8'h00;

  // ----------------------------------------------------------------
  // framing and geometry
  // ----------------------------------------------------------------
  localparam int ADDR_BYTES     = 3;
  localparam int SECTOR_LSB     = 16;  // 64 KB sectors
  localparam int SECTOR_BITS_DF = 6;   // 64-sector variant

  // ----------------------------------------------------------------
  // self-timed status write
  // ----------------------------------------------------------------
  localparam int CLK_KHZ       = 50000;
  localparam int WS_TYP_MS     = 10;
  localparam int WS_MAX_MS     = 15;
  localparam int WS_TYP_CYCLES = WS_TYP_MS * CLK_KHZ;

  // status register fields
  typedef struct packed {
    logic [1:0] reserved;
    logic       protect_origin;
    logic [2:0] protect_level;
    logic       write_permit_latch;
    logic       busy_flag;
  } sfp_status_type;

  // command handed to the array engine
  typedef struct packed {
    logic [7:0]  op;
    logic [23:0] addr;
    logic [7:0]  data;
  } sfp_array_cmd_type;

  // frame progress states
  typedef enum logic [2:0] {
    FR_OPCODE,
    FR_ADDR,
    FR_WDATA,
    FR_RDATA,
    FR_TAIL,
    FR_DROP
  } sfp_frame_type;

endpackage

/* File: rtl/sfp_protect_decode.sv */
// sfp_protect_decode: maps origin and level bits to a sector protect flag
`timescale 1ns/1ps

module sfp_protect_decode #(
  parameter int SECTOR_BITS = sfp_pkg::SECTOR_BITS_DF
) (
  input  wire logic                   protect_origin,
  input  wire logic [2:0]             protect_level,
  input  wire logic [SECTOR_BITS-1:0] sector,
  output logic                        is_protected
);

  // larger parts start at two or more sectors per level step
  localparam int SHIFT = (SECTOR_BITS > 6) ? SECTOR_BITS - 6 : 0;

  // ----------------------------------------------------------------
  // range decode: level n guards 2^(n-1+SHIFT) sectors at the origin
  // ----------------------------------------------------------------
  always_comb begin
    int span;
    int high;
    int lim;
    span = int'(protect_level) - 1 + SHIFT;
    high = 0;
    lim  = 0;
    if (protect_level == 3'd0) begin
      is_protected = 1'b0;
    end else if (span >= SECTOR_BITS) begin
      is_protected = 1'b1;
    end else begin
      high = int'(sector) >> span;
      lim  = (1 << (SECTOR_BITS - span)) - 1;
      if (protect_origin) begin
        is_protected = (high == 0);
      end else begin
        is_protected = (high == lim);
      end
    end
  end

endmodule

/* File: rtl/sfp_flash_front.sv */
// sfp_flash_front: serial command front end with status and block protection
`timescale 1ns/1ps

module sfp_flash_front #(
  parameter int SECTOR_BITS = sfp_pkg::SECTOR_BITS_DF,
  parameter int WS_CYCLES   = sfp_pkg::WS_TYP_CYCLES
) (
  input  wire logic                       mclk,
  input  wire logic                       reset,
  input  wire logic                       select_low,
  input  wire logic                       link_clock_in,
  input  wire logic                       serial_in_line,
  output logic [3:0]                      data_out,
  output logic [3:0]                      data_oe,
  output sfp_pkg::sfp_array_cmd_type      array_cmd,
  output logic                            array_start,
  input  wire logic                       array_done,
  output logic [23:0]                     array_rd_addr,
  input  wire logic [7:0]                 array_rd_data,
  output logic [7:0]                      status_out
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic                       sel_s1_q, sel_s2_q, sel_s3_q;
  logic                       lck_s1_q, lck_s2_q, lck_s3_q;
  logic                       din_s1_q, din_s2_q;
  logic                       rise, fall, active, frame_end;
  sfp_pkg::sfp_frame_type     frame_q;
  logic [2:0]                 bit_cnt_q;
  logic [1:0]                 addr_cnt_q;
  logic [7:0]                 shift_q;
  logic [7:0]                 shift_d;
  logic [7:0]                 op_q;
  logic [23:0]                addr_q;
  logic [7:0]                 wdata_q;
  logic                       got_data_q;
  logic [7:0]                 tx_q;
  logic [2:0]                 tx_cnt_q;
  logic                       out_bit_q;
  logic                       oe_q;
  sfp_pkg::sfp_status_type    status_q;
  logic [7:0]                 ws_data_q;
  logic [$clog2(WS_CYCLES+1)-1:0] ws_cnt_q;
  logic                       ws_active_q;
  logic                       arr_busy_q;
  logic                       busy;
  logic                       is_protected;
  logic                       clean_end;
  logic                       go_ws, go_wr, go_se, go_be;
  sfp_pkg::sfp_array_cmd_type cmd_q;
  logic                       start_q;
  logic [7:0]                 next_byte;

  // decides whether an opcode touches the array
  function automatic logic is_array_op(input logic [7:0] op);
    is_array_op = (op == sfp_pkg::OP_READ_BYTES) || (op == sfp_pkg::OP_WRITE_BYTES) ||
                  (op == sfp_pkg::OP_ERASE_SECTOR) || (op == sfp_pkg::OP_ERASE_BULK) ||
                  (op == sfp_pkg::OP_ERASE_DIE);
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers and link edge detection
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      sel_s1_q <= 1'b1;
      sel_s2_q <= 1'b1;
      sel_s3_q <= 1'b1;
      lck_s1_q <= 1'b0;
      lck_s2_q <= 1'b0;
      lck_s3_q <= 1'b0;
      din_s1_q <= 1'b0;
      din_s2_q <= 1'b0;
    end else begin
      sel_s1_q <= select_low;
      sel_s2_q <= sel_s1_q;
      sel_s3_q <= sel_s2_q;
      lck_s1_q <= link_clock_in;
      lck_s2_q <= lck_s1_q;
      lck_s3_q <= lck_s2_q;
      din_s1_q <= serial_in_line;
      din_s2_q <= din_s1_q;
    end
  end

  // edges only count inside a frame
  assign active    = ~sel_s2_q;
  assign rise      = active & lck_s2_q & ~lck_s3_q;
  assign fall      = active & ~lck_s2_q & lck_s3_q;
  assign frame_end = sel_s2_q & ~sel_s3_q;
  assign shift_d   = {shift_q[6:0], din_s2_q};
  assign busy      = ws_active_q | arr_busy_q;

  // ----------------------------------------------------------------
  // protection decode on the addressed sector
  // ----------------------------------------------------------------
  sfp_protect_decode #(
    .SECTOR_BITS (SECTOR_BITS)
  ) u_decode (
    .protect_origin (status_q.protect_origin),
    .protect_level  (status_q.protect_level),
    .sector         (addr_q[sfp_pkg::SECTOR_LSB +: SECTOR_BITS]),
    .is_protected   (is_protected)
  );

  // ----------------------------------------------------------------
  // incoming frame: opcode, address, data bytes
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset || !active) begin
      frame_q    <= sfp_pkg::FR_OPCODE;
      bit_cnt_q  <= 3'd0;
      addr_cnt_q <= 2'd0;
      shift_q    <= 8'h00;
      got_data_q <= 1'b0;
    end else if (rise) begin
      shift_q   <= shift_d;
      bit_cnt_q <= bit_cnt_q + 3'd1;
      if (bit_cnt_q == 3'd7) begin
        case (frame_q)
          sfp_pkg::FR_OPCODE: begin
            if (is_array_op(shift_d) && busy) begin
              frame_q <= sfp_pkg::FR_DROP;
            end else begin
              case (shift_d)
                sfp_pkg::OP_READ_STATUS:  frame_q <= sfp_pkg::FR_RDATA;
                sfp_pkg::OP_WRITE_STATUS: frame_q <= sfp_pkg::FR_WDATA;
                sfp_pkg::OP_READ_BYTES,
                sfp_pkg::OP_WRITE_BYTES,
                sfp_pkg::OP_ERASE_SECTOR: frame_q <= sfp_pkg::FR_ADDR;
                sfp_pkg::OP_WRITE_ON,
                sfp_pkg::OP_WRITE_OFF,
                sfp_pkg::OP_ERASE_BULK,
                sfp_pkg::OP_ERASE_DIE:    frame_q <= sfp_pkg::FR_TAIL;
                default:                  frame_q <= sfp_pkg::FR_DROP;
              endcase
            end
          end
          sfp_pkg::FR_ADDR: begin
            addr_cnt_q <= addr_cnt_q + 2'd1;
            if (addr_cnt_q == 2'(sfp_pkg::ADDR_BYTES - 1)) begin
              if (op_q == sfp_pkg::OP_READ_BYTES) begin
                frame_q <= sfp_pkg::FR_RDATA;
              end else if (op_q == sfp_pkg::OP_WRITE_BYTES) begin
                frame_q <= sfp_pkg::FR_WDATA;
              end else begin
                frame_q <= sfp_pkg::FR_TAIL;
              end
            end
          end
          sfp_pkg::FR_WDATA: got_data_q <= 1'b1;
          default:           frame_q <= frame_q;
        endcase
      end
    end
  end

  // opcode, address and data capture
  always_ff @(posedge mclk) begin
    if (reset) begin
      op_q    <= 8'h00;
      addr_q  <= 24'h00_0000;
      wdata_q <= 8'h00;
    end else if (rise && bit_cnt_q == 3'd7) begin
      if (frame_q == sfp_pkg::FR_OPCODE) begin
        op_q <= shift_d;
      end
      if (frame_q == sfp_pkg::FR_ADDR) begin
        addr_q <= {addr_q[15:0], shift_d};
      end
      if (frame_q == sfp_pkg::FR_WDATA) begin
        wdata_q <= shift_d;
      end
    end else if (fall && frame_q == sfp_pkg::FR_RDATA && tx_cnt_q == 3'd0 &&
                 op_q == sfp_pkg::OP_READ_BYTES) begin
      addr_q <= addr_q + 24'h00_0001;                  // sequential read
    end
  end

  // ----------------------------------------------------------------
  // outgoing data: status or array bytes, shifted on falling edges
  // ----------------------------------------------------------------
  assign next_byte = (op_q == sfp_pkg::OP_READ_STATUS) ? status_q : array_rd_data;

  always_ff @(posedge mclk) begin
    if (reset || !active) begin
      tx_q      <= 8'h00;
      tx_cnt_q  <= 3'd0;
      out_bit_q <= 1'b0;
      oe_q      <= 1'b0;
    end else if (fall && frame_q == sfp_pkg::FR_RDATA) begin
      oe_q     <= 1'b1;
      tx_cnt_q <= tx_cnt_q + 3'd1;
      if (tx_cnt_q == 3'd0) begin
        out_bit_q <= next_byte[7];
        tx_q      <= {next_byte[6:0], 1'b0};
      end else begin
        out_bit_q <= tx_q[7];
        tx_q      <= {tx_q[6:0], 1'b0};
      end
    end
  end

  // single-line reads use lane 1 of the group
  assign data_out      = {2'b00, out_bit_q, 1'b0};
  assign data_oe       = {2'b00, oe_q, 1'b0};
  assign array_rd_addr = addr_q;

  // ----------------------------------------------------------------
  // end-of-frame checks
  // ----------------------------------------------------------------
  assign clean_end = frame_end && bit_cnt_q == 3'd0;
  assign go_ws = clean_end && op_q == sfp_pkg::OP_WRITE_STATUS && got_data_q &&
                 status_q.write_permit_latch && !busy;
  assign go_wr = clean_end && op_q == sfp_pkg::OP_WRITE_BYTES && got_data_q &&
                 status_q.write_permit_latch && !busy && !is_protected;
  assign go_se = clean_end && op_q == sfp_pkg::OP_ERASE_SECTOR &&
                 frame_q == sfp_pkg::FR_TAIL &&
                 status_q.write_permit_latch && !busy && !is_protected;
  assign go_be = clean_end && (op_q == sfp_pkg::OP_ERASE_BULK || op_q == sfp_pkg::OP_ERASE_DIE) &&
                 frame_q == sfp_pkg::FR_TAIL && status_q.write_permit_latch && !busy &&
                 status_q.protect_level == 3'd0;

  // ----------------------------------------------------------------
  // array command hand-off and busy tracking
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      cmd_q   <= '0;
      start_q <= 1'b0;
    end else begin
      start_q <= go_wr | go_se | go_be;
      if (go_wr | go_se | go_be) begin
        cmd_q <= '{op: op_q, addr: addr_q, data: wdata_q};
      end
    end
  end

  assign array_cmd   = cmd_q;
  assign array_start = start_q;

  // set wins over the done pulse
  always_ff @(posedge mclk) begin
    if (reset) begin
      arr_busy_q <= 1'b0;
    end else if (go_wr | go_se | go_be) begin
      arr_busy_q <= 1'b1;
    end else if (array_done) begin
      arr_busy_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // self-timed status write
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      ws_active_q <= 1'b0;
      ws_cnt_q    <= '0;
      ws_data_q   <= sfp_pkg::ST_RESET;
    end else if (go_ws) begin
      ws_active_q <= 1'b1;
      ws_cnt_q    <= ($clog2(WS_CYCLES+1))'(WS_CYCLES - 1);
      ws_data_q   <= wdata_q;
    end else if (ws_active_q) begin
      if (ws_cnt_q == '0) begin
        ws_active_q <= 1'b0;
      end else begin
        ws_cnt_q <= ws_cnt_q - 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // status register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      status_q <= sfp_pkg::ST_RESET;
    end else begin
      status_q.busy_flag <= busy;
      if (ws_active_q && ws_cnt_q == '0) begin
        // only bits 7..2 take the written data
        status_q.reserved       <= ws_data_q[sfp_pkg::ST_RSVD_LSB +: 2];
        status_q.protect_origin <= ws_data_q[sfp_pkg::ST_ORIGIN_POS];
        status_q.protect_level  <= ws_data_q[sfp_pkg::ST_LEVEL_LSB +: 3];
      end
      if (clean_end && frame_q == sfp_pkg::FR_TAIL && !busy) begin
        if (op_q == sfp_pkg::OP_WRITE_ON) begin
          status_q.write_permit_latch <= 1'b1;
        end else if (op_q == sfp_pkg::OP_WRITE_OFF) begin
          status_q.write_permit_latch <= 1'b0;
        end
      end
    end
  end

  assign status_out = status_q;

endmodule

/* File: verif/sfp_flash_front_assertions.sv */
// sfp_flash_front_assertions: port-level checks bound into the front end
`timescale 1ns/1ps

module sfp_flash_front_assertions #(
  parameter int SECTOR_BITS = 6,
  parameter int WS_CYCLES   = sfp_pkg::WS_TYP_CYCLES
) (
  input wire logic                       mclk,
  input wire logic                       reset,
  input wire logic                       select_low,
  input wire logic                       link_clock_in,
  input wire logic                       serial_in_line,
  input wire logic [3:0]                 data_out,
  input wire logic [3:0]                 data_oe,
  input wire sfp_pkg::sfp_array_cmd_type array_cmd,
  input wire logic                       array_start,
  input wire logic                       array_done,
  input wire logic [23:0]                array_rd_addr,
  input wire logic [7:0]                 array_rd_data,
  input wire logic [7:0]                 status_out
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  // ----------------------------------------------------------------
  // link output lanes and enables
  // ----------------------------------------------------------------
  property p_lanes;
    data_oe[3:2] == 2'h0 && !data_oe[0] && data_out[3:2] == 2'h0 && !data_out[0];
  endproperty
  a_lanes: assert property (p_lanes) else $error("unused data lane active");
  property p_oe_rise;
    $rose(data_oe[1]) |-> !select_low;
  endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("output enabled while deselected");
  property p_oe_idle;
    select_low [*6] |-> data_oe == 4'h0;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("output still enabled after deselect");

  // ----------------------------------------------------------------
  // array command launch
  // ----------------------------------------------------------------
  property p_start_frame;
    array_start |-> select_low;
  endproperty
  a_start_frame: assert property (p_start_frame) else $error("array start inside a frame");
  property p_start_pulse;
    array_start |=> !array_start [*4];
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("array start repeated");
  property p_start_idle;
    array_start |-> !status_out[0] && status_out[1];
  endproperty
  a_start_idle: assert property (p_start_idle) else $error("array start while busy or unpermitted");
  property p_erase_all;
    array_start && (array_cmd.op == sfp_pkg::OP_ERASE_BULK || array_cmd.op == sfp_pkg::OP_ERASE_DIE)
      |-> status_out[4:2] == 3'h0;
  endproperty
  a_erase_all: assert property (p_erase_all) else $error("full erase with level set");

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  property p_busy_set;
    array_start |-> ##[1:3] status_out[0];
  endproperty
  a_busy_set: assert property (p_busy_set) else $error("busy not raised after start");
  property p_busy_hold;
    $rose(status_out[0]) |-> status_out[0] [*8];
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");
  property p_level_update;
    $changed(status_out[7:2]) |-> $past(status_out[0]);
  endproperty
  a_level_update: assert property (p_level_update) else $error("level changed outside a cycle");
  property p_permit_rise;
    $rose(status_out[1]) |-> select_low && !status_out[0];
  endproperty
  a_permit_rise: assert property (p_permit_rise) else $error("permit set inside a frame");

  // main scenarios reached
  c_start: cover property (array_start);
  c_read: cover property ($rose(data_oe[1]));
  c_busy_end: cover property ($fell(status_out[0]));
endmodule

bind sfp_flash_front sfp_flash_front_assertions #(.SECTOR_BITS(SECTOR_BITS), .WS_CYCLES(WS_CYCLES))
  i_sfp_flash_front_assertions (.mclk(mclk), .reset(reset), .select_low(select_low),
  .link_clock_in(link_clock_in), .serial_in_line(serial_in_line), .data_out(data_out), .data_oe(data_oe),
  .array_cmd(array_cmd), .array_start(array_start), .array_done(array_done), .array_rd_addr(array_rd_addr),
  .array_rd_data(array_rd_data), .status_out(status_out));

/* File: verif/sfp_host_model.sv */
// sfp_host_model: configuration host driving the serial link
`timescale 1ns/1ps

module sfp_host_model (
  input wire logic       mclk,
  input wire logic [3:0] data_out,
  input wire logic [3:0] data_oe,
  output logic           select_low,
  output logic           link_clock_in,
  output logic           serial_in_line
);
  // link idle: deselected, clock parked low
  initial begin
    select_low     = 1'b1;
    link_clock_in  = 1'b0;
    serial_in_line = 1'b0;
  end

  // one frame of nbits, clock low 5 mclk and high 3 mclk
  task automatic xfer(input logic [63:0] tx, input int nbits, output logic [63:0] rx);
    logic last;
    last = 1'b0;
    rx   = '0;
    @(posedge mclk) #1 select_low = 1'b0;
    for (int i = nbits - 1; i >= 0; i--) begin
      serial_in_line = tx[i];
      repeat (5) @(posedge mclk);
      #1 link_clock_in = 1'b1;
      last = (data_oe[1] === 1'b1) ? data_out[1] : ~last; // released line shows no stale bit
      rx = {rx[62:0], last};
      repeat (3) @(posedge mclk);
      #1 link_clock_in = 1'b0;
    end
    repeat (4) @(posedge mclk);
    #1 select_low = 1'b1;
    serial_in_line = ~serial_in_line;
    repeat (8) @(posedge mclk);
  endtask
endmodule

/* File: verif/sfp_flash_front_test.sv */
// sfp_flash_front_test: link-level test of the serial flash front end
`timescale 1ns/1ps

module sfp_flash_front_test;
  localparam int WS = 300;
  logic                       mclk;
  logic                       reset;
  logic                       select_low;
  logic                       link_clock_in;
  logic                       serial_in_line;
  logic                       array_done;
  logic                       array_start;
  logic [3:0]                 data_out;
  logic [3:0]                 data_oe;
  logic [23:0]                array_rd_addr;
  logic [7:0]                 array_rd_data;
  logic [7:0]                 status_out;
  logic [7:0]                 s;
  logic [63:0]                rx;
  logic [63:0]                tx;
  logic                       start_8;
  logic                       start_32;
  sfp_pkg::sfp_array_cmd_type array_cmd;
  int                         miscompares = 0;
  int                         checks = 0;
  int                         starts = 0;
  int                         starts_8 = 0;
  int                         starts_32 = 0;

  // clock, array read data and start counting
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  assign array_rd_data = array_rd_addr[7:0] ^ 8'hA5;
  always @(posedge mclk) if (array_start === 1'b1) starts <= starts + 1;
  always @(posedge mclk) if (start_8 === 1'b1) starts_8 <= starts_8 + 1;
  always @(posedge mclk) if (start_32 === 1'b1) starts_32 <= starts_32 + 1;

  sfp_flash_front #(.SECTOR_BITS(6), .WS_CYCLES(WS)) i_sfp_flash_front (.mclk(mclk), .reset(reset),
    .select_low(select_low), .link_clock_in(link_clock_in), .serial_in_line(serial_in_line),
    .data_out(data_out), .data_oe(data_oe), .array_cmd(array_cmd), .array_start(array_start),
    .array_done(array_done), .array_rd_addr(array_rd_addr), .array_rd_data(array_rd_data),
    .status_out(status_out));
  sfp_host_model i_sfp_host_model (.mclk(mclk), .data_out(data_out), .data_oe(data_oe),
    .select_low(select_low), .link_clock_in(link_clock_in), .serial_in_line(serial_in_line));
  // 8- and 32-sector variants listen to the same frames
  sfp_flash_front #(.SECTOR_BITS(3), .WS_CYCLES(WS)) i_sfp_flash_front_8 (.mclk(mclk), .reset(reset),
    .select_low(select_low), .link_clock_in(link_clock_in), .serial_in_line(serial_in_line),
    .data_out(), .data_oe(), .array_cmd(), .array_start(start_8), .array_done(array_done),
    .array_rd_addr(), .array_rd_data(array_rd_data), .status_out());
  sfp_flash_front #(.SECTOR_BITS(5), .WS_CYCLES(WS)) i_sfp_flash_front_32 (.mclk(mclk), .reset(reset),
    .select_low(select_low), .link_clock_in(link_clock_in), .serial_in_line(serial_in_line),
    .data_out(), .data_oe(), .array_cmd(), .array_start(start_32), .array_done(array_done),
    .array_rd_addr(), .array_rd_data(array_rd_data), .status_out());

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task check_val(input string what, input logic [39:0] exp, input logic [39:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task conclude;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task cmd(input logic [63:0] t, input int n);
    i_sfp_host_model.xfer(t, n, rx);
  endtask
  task rd_status;
    cmd({8'h05, 8'h00}, 16);
    s = rx[7:0];
  endtask
  task wait_idle;
    int k;
    for (k = 0; k < 2000 && status_out[0] !== 1'b0; k++) @(posedge mclk) #1;
    if (k == 2000) begin
      miscompares++;
      conclude();
    end
  endtask
  task done_pulse;
    repeat (20) @(posedge mclk);
    #1 array_done = 1'b1;
    @(posedge mclk) #1 array_done = 1'b0;
    wait_idle();
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    reset = 1'b1;
    array_done = 1'b0;
    repeat (10) @(posedge mclk);
    #1 reset = 1'b0;
    repeat (2) @(posedge mclk);
    check_val("status_out", 40'h00, 40'(status_out));
    rd_status(); check_val("status read", 40'h00, 40'(s));
    cmd(64'({8'h01, 8'h1C}), 16); rd_status(); check_val("no permit", 40'h00, 40'(s));
    cmd(64'(8'h06), 8); rd_status(); check_val("permit", 40'h02, 40'(s));
    cmd(64'({8'h01, 8'h0F}), 16); rd_status(); check_val("busy read", 40'h03, 40'(s));
    wait_idle(); check_val("status_out", 40'h0E, 40'(status_out));
    cmd(64'({8'h05, 16'h0000}), 24); check_val("repeat", 40'h0E0E, 40'(rx[15:0]));
    cmd(64'({8'h02, 24'h3F_0000, 8'h5A}), 40); check_val("protected", 40'h0, 40'(starts));
    cmd(64'({8'h02, 24'h3B_FFFF, 8'hC3}), 40); check_val("open", 40'h1, 40'(starts));
    check_val("variant starts", 40'h0101, 40'({8'(starts_8), 8'(starts_32)}));
    check_val("array_cmd", {8'h02, 24'h3B_FFFF, 8'hC3}, array_cmd);
    cmd(64'({8'h02, 24'h00_0000, 8'h11}), 40); check_val("busy write", 40'h1, 40'(starts));
    rd_status(); check_val("busy array", 40'h0F, 40'(s));
    done_pulse();
    for (int i = 0; i < 3; i++) begin
      tx = 64'h0000_0000_D800_0000;
      tx = (i == 1) ? (tx << 1) : (i == 0) ? (tx >> 1) : tx;
      cmd(tx, 31 + 2 * (i % 2) + (i / 2));
      check_val("sector erase", (i == 2) ? 40'h2 : 40'h1, 40'(starts));
    end
    check_val("erase op", 40'(sfp_pkg::OP_ERASE_SECTOR), 40'(array_cmd.op));
    done_pulse();
    cmd(64'(sfp_pkg::OP_ERASE_BULK), 8); check_val("bulk locked", 40'h2, 40'(starts));
    cmd(64'({8'h01, 8'h00}), 16); wait_idle(); rd_status(); check_val("cleared", 40'h02, 40'(s));
    for (int i = 0; i < 2; i++) begin
      tx = (i == 0) ? 64'(sfp_pkg::OP_ERASE_BULK) : 64'(sfp_pkg::OP_ERASE_DIE);
      cmd(tx, 8); check_val("full erase", 40'(3 + i), 40'(starts));
      check_val("full op", 40'(tx[7:0]), 40'(array_cmd.op));
      done_pulse();
    end
    cmd(64'({8'h01, 8'h30}), 16); wait_idle();
    cmd(64'({8'h02, 24'h07_0000, 8'h77}), 40); check_val("bottom guarded", 40'h4, 40'(starts));
    cmd(64'({8'h02, 24'h08_0000, 8'h88}), 40); check_val("bottom open", 40'h5, 40'(starts));
    check_val("variant starts", 40'h0405, 40'({8'(starts_8), 8'(starts_32)}));
    done_pulse();
    cmd(64'(8'h04), 8); rd_status(); check_val("write off", 40'h30, 40'(s));
    cmd(64'({8'h02, 24'h3B_0000, 8'h00}), 40); check_val("no permit write", 40'h5, 40'(starts));
    cmd(64'({8'h03, 24'h00_0010, 19'h0_0000}), 51);
    check_val("read bytes", 40'({8'hB5, 8'hB4, 3'h5}), 40'(rx[18:0]));
    check_val("data_oe", 40'h0, 40'(data_oe));
    conclude();
  end
endmodule
